// ---- rtl/fpc_front_panel.sv ----
`timescale 1ns/1ps
// Contract
// - error: error screen, flash about 2 Hz
// - warning: slow flash about 1 Hz
// - mode button cycles four modes, selection only
// - set toggles selection and execution always
// - edits act on flashing-point digit only; points 4 and 5 edit digits 0 and 1
// - up increases, down decreases value
// - shift moves flashing decimal point
// - power-up shows initial display monitor item
// - alarm sequence repeats while alarm persists
// - overload/regeneration at 85 percent: codes 0,1
// - battery at or below 3.2 V: code 2
// - fan stopped one second: code 3
// - link errors over limit: codes 4, 9
// - codes 5-8 to overheat, oscillation, lifetime, scale
// - locked: monitor mode fully usable
// - locked: parameters viewable, not changeable
// - locked: nonvolatile write blocked, blank
// - locked: auxiliary blank except lock release
// - lock setting 1 saved: locked after power-up
// - release function then power cycle: unlocked
// - lock setting 0 via link: unlocked
// - monitor up/down step items with wrap
module fpc_front_panel
  import fpc_pkg::*;
#(
  parameter int FAN_CYC = FAN_STOP_CYC,
  parameter int ERR_CYC = ERR_HALF_CYC,
  parameter int WARN_CYC = WARN_HALF_CYC,
  parameter int DWELL_CYC = ALM_DWELL_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic btn_mode_i,
  input wire logic btn_set_i,
  input wire logic btn_up_i,
  input wire logic btn_down_i,
  input wire logic btn_shift_i,
  input wire logic error_i,
  input wire logic warning_i,
  input wire logic [7:0] overload_pct_i,
  input wire logic [7:0] regen_pct_i,
  input wire logic [11:0] batt_mv_i,
  input wire logic fan_stopped_i,
  input wire logic [7:0] enc_err_cnt_i,
  input wire logic [7:0] enc_err_limit_i,
  input wire logic [7:0] scale_err_cnt_i,
  input wire logic [7:0] scale_err_limit_i,
  input wire logic enc_overheat_i,
  input wire logic oscillation_i,
  input wire logic lifetime_i,
  input wire logic scale_alarm_i,
  input wire logic [5:0] initial_display_select_i,
  input wire logic panel_lock_setting_i,
  output logic [1:0] mode_o,
  output logic exec_o,
  output logic [5:0] mon_item_o,
  output logic [15:0] param_value_o,
  output logic param_write_o,
  output logic [2:0] dp_digit_o,
  output logic blank_o,
  output logic disp_on_o,
  output logic err_screen_o,
  output logic alarm_show_o,
  output logic [3:0] alarm_code_o,
  output logic [9:0] alarm_vec_o,
  output logic locked_o,
  output logic lock_release_o
);

  // ****************************************
  // button synchronisers and edge detect
  // ****************************************
  logic [4:0] btn_s1_reg, btn_s2_reg, btn_s3_reg;
  logic [4:0] press;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      btn_s1_reg <= 5'h00;
      btn_s2_reg <= 5'h00;
      btn_s3_reg <= 5'h00;
    end else begin
      btn_s1_reg <= {btn_shift_i, btn_down_i, btn_up_i, btn_set_i, btn_mode_i};
      btn_s2_reg <= btn_s1_reg;
      btn_s3_reg <= btn_s2_reg;
    end
  end
  // debounce assumed done off-block; presses are clean edges
  assign press = btn_s2_reg & ~btn_s3_reg;
  wire p_mode = press[0];
  wire p_set = press[1];
  wire p_up = press[2];
  wire p_down = press[3];
  wire p_shift = press[4];

  // ****************************************
  // alarm sources, synchronised
  // ****************************************
  logic [9:0] src_s1_reg, src_s2_reg;
  logic fan_s1_reg, fan_s2_reg;
  logic [9:0] alm_next;
  logic [31:0] fan_cnt_reg;
  logic fan_alarm_reg;
  always_comb begin
    alm_next = 10'h000;
    alm_next[0] = (overload_pct_i >= PCT_ALARM);
    alm_next[1] = (regen_pct_i >= PCT_ALARM);
    alm_next[2] = (batt_mv_i <= BATT_LIMIT_MV);
    alm_next[4] = (enc_err_cnt_i > enc_err_limit_i);
    alm_next[5] = enc_overheat_i;
    alm_next[6] = oscillation_i;
    alm_next[7] = lifetime_i;
    alm_next[8] = scale_alarm_i;
    alm_next[9] = (scale_err_cnt_i > scale_err_limit_i);
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      src_s1_reg <= 10'h000;
      src_s2_reg <= 10'h000;
      fan_s1_reg <= 1'b0;
      fan_s2_reg <= 1'b0;
    end else begin
      src_s1_reg <= alm_next;
      src_s2_reg <= src_s1_reg;
      fan_s1_reg <= fan_stopped_i;
      fan_s2_reg <= fan_s1_reg;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      fan_cnt_reg <= 32'h0;
      fan_alarm_reg <= 1'b0;
    end else if (!fan_s2_reg) begin
      fan_cnt_reg <= 32'h0;
      fan_alarm_reg <= 1'b0;
    end else if (fan_cnt_reg >= FAN_CYC - 1) begin
      fan_alarm_reg <= 1'b1;
    end else begin
      fan_cnt_reg <= fan_cnt_reg + 32'h1;
    end
  end
  wire [9:0] alarms = {src_s2_reg[9:4], fan_alarm_reg, src_s2_reg[2:0]};
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) alarm_vec_o <= 10'h000;
    else alarm_vec_o <= alarms;
  end

  // ****************************************
  // alarm code cycling
  // ****************************************
  function automatic logic [3:0] next_code(input logic [3:0] cur, input logic [9:0] v);
    logic [3:0] r;
    logic [3:0] k;
    r = cur;
    for (int i = 1; i <= NUM_ALARMS; i++) begin
      k = 4'((int'(cur) + i) % NUM_ALARMS);
      if (v[k] && r == cur) r = k;
    end
    return r;
  endfunction
  logic [31:0] dwell_reg;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dwell_reg <= 32'h0;
      alarm_code_o <= 4'h0;
      alarm_show_o <= 1'b0;
    end else if (alarms == 10'h000) begin
      dwell_reg <= 32'h0;
      alarm_show_o <= 1'b0;
    end else if (dwell_reg >= DWELL_CYC - 1 || !alarm_show_o) begin
      dwell_reg <= 32'h0;
      alarm_show_o <= 1'b1;
      alarm_code_o <= next_code(alarm_code_o, alarms);
    end else begin
      dwell_reg <= dwell_reg + 32'h1;
    end
  end

  // ****************************************
  // flash timing
  // ****************************************
  logic [31:0] flash_cnt_reg;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      flash_cnt_reg <= 32'h0;
      disp_on_o <= 1'b1;
    end else if (!error_i && !warning_i) begin
      flash_cnt_reg <= 32'h0;
      disp_on_o <= 1'b1;
    end else if (flash_cnt_reg >= (error_i ? ERR_CYC : WARN_CYC) - 1) begin
      flash_cnt_reg <= 32'h0;
      disp_on_o <= ~disp_on_o;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) err_screen_o <= 1'b0;
    else err_screen_o <= error_i;
  end

  // ****************************************
  // lock capture, once after power-up
  // ****************************************
  fpc_state_e st_reg;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) locked_o <= 1'b0;
    else if (st_reg == FPC_BOOT) locked_o <= panel_lock_setting_i;
  end

  // ****************************************
  // mode and display state
  // ****************************************
  fpc_mode_e mode_reg;
  wire lk = locked_o;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_reg <= FPC_BOOT;
      mode_reg <= FPC_MON;
    end else begin
      case (st_reg)
        FPC_BOOT: begin
          st_reg <= FPC_EXE;
        end
        FPC_SEL: begin
          if (p_set) st_reg <= FPC_EXE;
          else if (p_mode) begin
            case (mode_reg)
              FPC_MON: mode_reg <= FPC_PAR;
              FPC_PAR: mode_reg <= FPC_EEP;
              FPC_EEP: mode_reg <= FPC_AUX;
              default: mode_reg <= FPC_MON;
            endcase
          end
        end
        default: begin
          if (p_set) st_reg <= FPC_SEL;
        end
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mode_o <= 2'b00;
      exec_o <= 1'b0;
    end else begin
      mode_o <= mode_reg;
      exec_o <= (st_reg == FPC_EXE);
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) blank_o <= 1'b0;
    else blank_o <= lk && (mode_reg == FPC_EEP || mode_reg == FPC_AUX);
  end

  // ****************************************
  // monitor item select
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) mon_item_o <= 6'h00;
    else if (st_reg == FPC_BOOT) begin
      mon_item_o <= (initial_display_select_i < MON_ITEMS) ? initial_display_select_i : 6'h00;
    end else if (st_reg == FPC_SEL && mode_reg == FPC_MON) begin
      if (p_up) mon_item_o <= (mon_item_o == MON_ITEMS - 6'h01) ? 6'h00 : mon_item_o + 6'h01;
      else if (p_down) mon_item_o <= (mon_item_o == 6'h00) ? MON_ITEMS - 6'h01 : mon_item_o - 6'h01;
    end
  end

  // ****************************************
  // digit select and value edit
  // ****************************************
  wire edit_ok = (st_reg == FPC_EXE) && (mode_reg == FPC_PAR) && !lk;
  logic [15:0] step;
  logic [3:0] shamt;
  always_comb begin
    shamt = {dp_digit_o[1:0], 2'b00};
    step = 16'h0001 << shamt;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) dp_digit_o <= DIGIT_RST;
    else if (p_shift && st_reg == FPC_EXE)
      dp_digit_o <= (dp_digit_o == 3'(NUM_DIGITS - 1)) ? 3'h0 : dp_digit_o + 3'h1;
  end
  // only four hex digits carry value; upper two fold back onto them
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      param_value_o <= PARAM_RST;
      param_write_o <= 1'b0;
    end else begin
      param_write_o <= edit_ok && (p_up || p_down);
      if (edit_ok && p_up) param_value_o <= param_value_o + step;
      else if (edit_ok && p_down) param_value_o <= param_value_o - step;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) lock_release_o <= 1'b0;
    else lock_release_o <= (st_reg == FPC_EXE) && (mode_reg == FPC_AUX) && p_up;
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_lock_hold;
    @(posedge mclk_i) disable iff (!rst_b_i) (st_reg != FPC_BOOT) |=> $stable(locked_o);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock changed after power-up");
  property p_no_edit_locked;
    @(posedge mclk_i) disable iff (!rst_b_i) locked_o |=> !param_write_o;
  endproperty
  a_no_edit_locked: assert property (p_no_edit_locked) else $error("parameter written while locked");
  property p_blank;
    @(posedge mclk_i) disable iff (!rst_b_i) (locked_o && mode_reg == FPC_EEP) |=> blank_o;
  endproperty
  a_blank: assert property (p_blank) else $error("write mode not blanked");
  property p_up_inc;
    @(posedge mclk_i) disable iff (!rst_b_i) (edit_ok && p_up) |=> param_value_o == $past(param_value_o) + $past(step);
  endproperty
  a_up_inc: assert property (p_up_inc) else $error("up did not add digit step");
  property p_mode_sel;
    @(posedge mclk_i) disable iff (!rst_b_i) (st_reg == FPC_EXE && p_mode) |=> $stable(mode_reg);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode changed in execution");
  property p_set_tog;
    @(posedge mclk_i) disable iff (!rst_b_i) (st_reg == FPC_SEL && p_set) |=> st_reg == FPC_EXE;
  endproperty
  a_set_tog: assert property (p_set_tog) else $error("set did not toggle");
  property p_wrap;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_reg == FPC_SEL && mode_reg == FPC_MON && p_up && mon_item_o == MON_ITEMS - 6'h01) |=> mon_item_o == 6'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("monitor item no wrap");
  property p_ovl;
    @(posedge mclk_i) disable iff (!rst_b_i) (overload_pct_i >= PCT_ALARM) [*3] |-> alarms[0];
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload alarm missing");
  property p_batt;
    @(posedge mclk_i) disable iff (!rst_b_i) (batt_mv_i > BATT_LIMIT_MV) [*3] |-> !alarms[2];
  endproperty
  a_batt: assert property (p_batt) else $error("battery alarm false");
  property p_steady;
    @(posedge mclk_i) disable iff (!rst_b_i) (!error_i && !warning_i) |=> disp_on_o;
  endproperty
  a_steady: assert property (p_steady) else $error("display dark without event");
  c_err: cover property (@(posedge mclk_i) error_i ##1 $fell(disp_on_o));
  c_alarm: cover property (@(posedge mclk_i) alarm_show_o ##1 $changed(alarm_code_o));
  c_edit: cover property (@(posedge mclk_i) param_write_o);
  c_rel: cover property (@(posedge mclk_i) lock_release_o);
endmodule

// ---- common/fpc_pkg.sv ----
package fpc_pkg;
  localparam int CLK_HZ = 10000000;
  // flash periods: half period toggles
  localparam int ERR_FLASH_HZ = 2;
  localparam int WARN_FLASH_HZ = 1;
  localparam int ERR_HALF_CYC = CLK_HZ / (2 * ERR_FLASH_HZ);
  localparam int WARN_HALF_CYC = CLK_HZ / (2 * WARN_FLASH_HZ);
  localparam int FAN_STOP_MS = 1000;
  localparam int FAN_STOP_CYC = (CLK_HZ / 1000) * FAN_STOP_MS;
  // alarm cycling dwell per code
  localparam int ALM_DWELL_MS = 500;
  localparam int ALM_DWELL_CYC = (CLK_HZ / 1000) * ALM_DWELL_MS;
  localparam logic [7:0] PCT_ALARM = 8'h55;
  localparam logic [11:0] BATT_LIMIT_MV = 12'hc80;
  localparam int NUM_ALARMS = 10;
  localparam int NUM_DIGITS = 6;
  localparam logic [5:0] MON_ITEMS = 6'h24;
  localparam logic [15:0] PARAM_RST = 16'h0000;
  localparam logic [2:0] DIGIT_RST = 3'h0;
  typedef enum logic [1:0] {
    FPC_MON = 2'b00,
    FPC_PAR = 2'b01,
    FPC_EEP = 2'b11,
    FPC_AUX = 2'b10
  } fpc_mode_e;
  typedef enum logic [1:0] {
    FPC_BOOT = 2'b00,
    FPC_SEL = 2'b01,
    FPC_EXE = 2'b11
  } fpc_state_e;
endpackage

// ---- sim/fpc_operator.sv ----
`timescale 1ns/1ps
// ****************************************
// operator at the buttons, lock storage
// ****************************************
module fpc_operator (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [2:0] btn_sel_i,
  input wire logic save_i,
  input wire logic save_val_i,
  output logic [4:0] btn_o,
  output logic busy_o,
  output logic panel_lock_setting_o
);
  logic [3:0] cnt_reg = 4'h0;
  initial begin
    btn_o = 5'h0;
    panel_lock_setting_o = 1'b0;
  end
  // held 4 cycles, then 5 low: sync flops need the gap
  always @(posedge mclk_i) begin
    if (go_i && cnt_reg == 4'h0) begin
      btn_o <= 5'h01 << btn_sel_i;
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h5) begin
        btn_o <= 5'h0;
      end
    end
  end
  assign busy_o = go_i || (cnt_reg != 4'h0);
  // stored setting changes only on a save
  always @(posedge mclk_i) begin
    if (save_i) begin
      panel_lock_setting_o <= save_val_i;
    end
  end
endmodule

// ---- sim/fpc_front_panel_tb_top.sv ----
`timescale 1ns/1ps
module fpc_front_panel_tb_top
  import fpc_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_b = 1'b0, go = 1'b0, sv = 1'b0, sv_val = 1'b0, err = 1'b0, warn = 1'b0;
  logic [2:0] btn_sel = 3'h0;
  logic [4:0] btn;
  logic busy, lock_set, fan = 1'b0, ovh = 1'b0, osc = 1'b0, life = 1'b0, scl = 1'b0;
  logic [7:0] ovl = 8'h0, rgn = 8'h0, ecnt = 8'h0, elim = 8'h0, scnt = 8'h0, slim = 8'h0;
  logic [11:0] batt = 12'hfff;
  logic [5:0] init_sel = 6'h0, mon_item_o;
  logic [1:0] mode_o;
  logic exec_o, wr_o, blank_o, disp_on_o, err_scr_o, show_o, locked_o, rel_o;
  logic [15:0] param_value_o;
  logic [2:0] dp_digit_o;
  logic [3:0] code_o;
  logic [9:0] vec_o;
  logic [31:0] seed = 32'h9f8e760a;
  int fails = 0, samples_checked = 0, wr_seen, rel_seen;
  int mi, ex, item, pv, dp, lk, nwr, nrel;
  fpc_mode_e codes[4] = '{FPC_MON, FPC_PAR, FPC_EEP, FPC_AUX};
  int seq[12] = '{1, 3, 0, 1, 2, 1, 0, 1, 1, 0, 1, 2};
  always #50 mclk_i = ~mclk_i;
  fpc_operator i_fpc_operator (.mclk_i(mclk_i), .go_i(go), .btn_sel_i(btn_sel), .save_i(sv),
    .save_val_i(sv_val), .btn_o(btn), .busy_o(busy), .panel_lock_setting_o(lock_set));
  fpc_front_panel #(.FAN_CYC(10), .ERR_CYC(4), .WARN_CYC(8), .DWELL_CYC(6)) i_fpc_front_panel (
    .mclk_i(mclk_i), .rst_b_i(rst_b), .btn_mode_i(btn[0]), .btn_set_i(btn[1]), .btn_up_i(btn[2]),
    .btn_down_i(btn[3]), .btn_shift_i(btn[4]), .error_i(err), .warning_i(warn), .overload_pct_i(ovl),
    .regen_pct_i(rgn), .batt_mv_i(batt), .fan_stopped_i(fan), .enc_err_cnt_i(ecnt), .enc_err_limit_i(elim),
    .scale_err_cnt_i(scnt), .scale_err_limit_i(slim), .enc_overheat_i(ovh), .oscillation_i(osc),
    .lifetime_i(life), .scale_alarm_i(scl), .initial_display_select_i(init_sel),
    .panel_lock_setting_i(lock_set), .mode_o(mode_o), .exec_o(exec_o), .mon_item_o(mon_item_o),
    .param_value_o(param_value_o), .param_write_o(wr_o), .dp_digit_o(dp_digit_o), .blank_o(blank_o),
    .disp_on_o(disp_on_o), .err_screen_o(err_scr_o), .alarm_show_o(show_o), .alarm_code_o(code_o),
    .alarm_vec_o(vec_o), .locked_o(locked_o), .lock_release_o(rel_o));
  // one-cycle pulses are counted, so no check can miss them
  always @(posedge mclk_i) begin
    wr_seen <= rst_b ? wr_seen + int'(wr_o) : 0;
    rel_seen <= rst_b ? rel_seen + int'(rel_o) : 0;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic power_up(input logic lock);
    @(posedge mclk_i);
    rst_b <= 1'b0;
    init_sel <= 6'(rnd() % 36);
    sv <= 1'b1;
    sv_val <= lock;
    repeat (5) @(posedge mclk_i);
    sv <= 1'b0;
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    {mi, ex, item, pv, dp, lk, nwr, nrel} = {32'd0, 32'd1, 26'd0, init_sel, 32'd0, 32'd0, 31'd0, lock, 64'd0};
    chk(mon_item_o, item);
    chk(locked_o, lk);
    chk(disp_on_o, 1);
  endtask
  task automatic act(input int b);
    int k, st;
    @(posedge mclk_i);
    btn_sel <= 3'(b);
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    for (k = 0; k < 20 && busy; k++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    #1;
    st = 16 ** (dp % 4);
    case (b)
      0: if (!ex) mi = (mi + 1) % 4;
      1: ex = !ex;
      4: if (ex) dp = (dp + 1) % 6;
      default: begin
        if (mi == 0 && !ex) item = (item + (b == 2 ? 1 : 35)) % 36;
        if (mi == 1 && ex && !lk) begin
          pv = (pv + (b == 2 ? st : 65536 - st)) % 65536;
          nwr++;
        end
        if (mi == 3 && ex && b == 2) nrel++;
      end
    endcase
    chk(mode_o, codes[mi]);
    chk(exec_o, ex);
    chk(mon_item_o, item);
    chk(param_value_o, pv);
    chk(dp_digit_o, dp);
    chk(wr_seen, nwr);
    chk(rel_seen, nrel);
    if (ex) chk(blank_o, lk && mi >= 2);
  endtask
  task automatic flash(input logic e, input logic w, input int half);
    int n;
    logic v;
    @(posedge mclk_i);
    err <= e;
    warn <= w;
    repeat (3) @(posedge mclk_i);
    for (int p = 0; p < 2; p++) begin
      v = disp_on_o;
      for (n = 0; n < 40 && disp_on_o === v; n++) begin
        @(posedge mclk_i);
        #1;
      end
    end
    chk(n, half);
    chk(err_scr_o, e);
  endtask
  initial begin
    #(100 * 20000);
    fails++;
    stop_test();
  end
  initial begin
    logic [31:0] r;
    logic [9:0] e;
    power_up(1'b0);
    // ****************************************
    // mode walk, refusals, editing
    // ****************************************
    foreach (seq[i]) act(i < 2 ? seq[i] : (i < 6 ? 0 : seq[i]));
    // back to parameter execution so the random presses really edit
    for (int i = 0; i < 5; i++) act(i % 4 == 0 ? 1 : 0);
    for (int i = 0; i < 10; i++) act(2 + int'(rnd() % 3));
    $display("test panel done");
    flash(1'b1, 1'b0, 4);
    flash(1'b0, 1'b1, 8);
    flash(1'b0, 1'b0, 40);
    $display("test flash done");
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk_i);
      r = rnd();
      {ovl, rgn, batt} <= {8'h50 + 8'(r[3:0]), 8'h50 + 8'(r[7:4]), 12'hc78 + 12'(r[11:8])};
      {fan, ecnt, elim, scnt, slim} <= {r[12], 8'(r[14:13]), 8'h01, 8'(r[16:15]), 8'h02};
      {scl, life, osc, ovh} <= r[20:17];
      e = {r[16:15] > 2, r[20:17], r[14:13] > 1, r[12], r[11:8] <= 8, r[7:4] >= 5, r[3:0] >= 5};
      repeat (16) @(posedge mclk_i);
      #1;
      chk(vec_o, e);
      chk(show_o, e != 0);
      if (e != 0) chk(e[code_o], 1);
    end
    $display("test alarms done");
    power_up(1'b1);
    foreach (seq[i]) act(seq[i]);
    act(1);
    act(0);
    act(1);
    act(1);
    act(0);
    act(1);
    act(2);
    @(posedge mclk_i);
    sv <= 1'b1;
    sv_val <= 1'b0;
    repeat (3) @(posedge mclk_i);
    sv <= 1'b0;
    #1;
    chk(locked_o, 1);
    power_up(1'b0);
    $display("test lock done");
    stop_test();
  end
endmodule
